// *** core/deac_pkg.sv ***
// Package for the data EEPROM access controller: register map, field layout, timing.
// Assumes a 20 MHz system clock and an APB register port with 32-bit data.
package deac_pkg;
    localparam int          DEAC_CLK_HZ          = 20000000;
    localparam int          DEAC_PROG_TIME_US    = 5;
    localparam int          DEAC_PROG_CYCLES     = (DEAC_PROG_TIME_US * (DEAC_CLK_HZ / 1000000));
    localparam int          DEAC_ADDR_W          = 12;
    localparam int          DEAC_ROW_W           = 2;
    localparam int          DEAC_COL_W           = 5;
    localparam int          DEAC_NUM_LATCH       = 32;
    localparam int          DEAC_ARRAY_BYTES     = 128;
    localparam int          DEAC_CNT_W           = 24;
    // Byte addresses on APB
    localparam logic [11:0] DEAC_CSR_ADDR        = 12'h030;
    localparam logic [11:0] DEAC_CFG_ADDR        = 12'h034;
    localparam logic [11:0] DEAC_ARRAY_BASE      = 12'h800;
    localparam logic [11:0] DEAC_ARRAY_MASK      = 12'hf80;
    // Control/status and config field positions, reset and fill values
    localparam int          DEAC_PGM_BIT         = 0;
    localparam int          DEAC_LAT_BIT         = 1;
    localparam int          DEAC_PROT_BIT        = 0;
    localparam logic [7:0]  DEAC_CSR_RESET       = 8'h00;
    localparam logic [7:0]  DEAC_ERASED_BYTE     = 8'hff;
    localparam logic [31:0] DEAC_UNDRIVEN_WORD   = 32'h0000_0000;

    typedef enum logic [3:0] {
        DEAC_IDLE   = 4'b0001,
        DEAC_PROG   = 4'b0010,
        DEAC_WAIT   = 4'b0100,
        DEAC_HALT   = 4'b1000
    } deac_state_t;
endpackage

// *** core/deac_top.sv ***
// Data EEPROM access controller: array storage, page latches, control/status register, APB slave.
// Assumes CPU core drives wait/halt requests and protection option as same-clock logic levels.
//
// Contract
// - Latch-mode 0: array reads like plain read-only memory.
// - Latch-mode 1, program 0: writes fill one of 32 page latches.
// - Setting program bit commits all latched bytes, up to 32, in one cycle.
// - Row comes from last latched write; software keeps upper address fixed.
// - Cycle end clears program and latch-mode bits in the same clock.
// - Repeat write to a latch stores AND of old and new byte.
// - Latches clear only at cycle end, latch-mode falling edge, in halt or at reset.
// - Page latch contents are never readable.
// - Wait request: idle enters wait now; programming finishes first.
// - Halt request enters halt at once, abandoning programming.
// - Array read while latch-mode is 1 returns undriven data.
// - Array write while latch-mode is 0 is ignored.
// - Reset during programming aborts the cycle; array contents undefined.
// - Protection blocks external read and rewrite; removing it erases array.
// - Latch-mode at bit 1, program at bit 0, bits 7:2 read zero.
// - Software clears latch-mode only while program bit is 0.
// - Program bit reads 1 throughout a running cycle; here a software write of 0 clears it mid-cycle.
// - Control/status resets to 00h.
// - Cycle duration timed internally, no software involvement.
`timescale 1ns/1ps
module deac_top
    import deac_pkg::*;
#(
    parameter int PROG_CYCLES = DEAC_PROG_CYCLES
)(
    input  wire logic        clk_in,           // System clock, 20 MHz
    input  wire logic        srst_in,          // Synchronous reset, active high
    input  wire logic        ce_in,            // Clock enable, freezes state when low
    input  wire logic        psel_in,          // APB select
    input  wire logic        penable_in,       // APB enable
    input  wire logic        pwrite_in,        // APB direction
    input  wire logic [11:0] paddr_in,         // APB byte address
    input  wire logic [31:0] pwdata_in,        // APB write data
    output logic      [31:0] prdata_out,       // APB read data
    output logic             pready_out,       // APB ready
    output logic             pslverr_out,      // APB error
    input  wire logic        wfi_req_in,       // Wait-for-interrupt or active-halt entry
    input  wire logic        halt_req_in,      // Halt instruction
    input  wire logic        protect_in,       // Read-out protection option level
    input  wire logic        ext_access_in,    // Current access comes from external tool
    output logic             busy_out,         // Programming cycle running
    output logic             wait_out,         // EEPROM in wait state
    output logic             halt_out          // EEPROM in halt state
);
    logic [7:0]              mem_q [DEAC_ARRAY_BYTES];
    logic [7:0]              latch_q [DEAC_NUM_LATCH];
    logic [DEAC_NUM_LATCH-1:0] lvalid_q;
    logic [DEAC_ROW_W-1:0]   row_q;
    logic                    lat_q;
    logic                    pgm_q;
    logic                    protect_q;
    deac_state_t             state_q;
    logic [DEAC_CNT_W-1:0]   cnt_q;
    logic [31:0]             prdata_q;
    logic                    slverr_q;

    logic                    acc;
    logic                    wr;
    logic                    hit_csr;
    logic                    hit_cfg;
    logic                    hit_arr;
    logic                    blocked;
    logic                    done;
    logic                    lat_fall;
    logic                    erase_all;
    logic [DEAC_COL_W-1:0]   col;
    logic [DEAC_ROW_W-1:0]   row;
    logic                    lat_d;
    logic                    pgm_d;
    logic                    setup;
    logic                    lwr;
    logic                    arr_rd_ok;
    logic [7:0]              csr_view;
    logic [DEAC_ARRAY_BYTES-1:0] commit;

    // Single-cycle access phase: slave always ready
    assign acc     = psel_in && penable_in && ce_in;
    assign wr      = acc && pwrite_in;
    assign col     = paddr_in[DEAC_COL_W-1:0];
    assign row     = paddr_in[DEAC_COL_W+DEAC_ROW_W-1:DEAC_COL_W];
    assign blocked = protect_q && ext_access_in;

    // Decode, strobe and commit helpers
    // Setup-phase strobe: read data is loaded here so it stands through the access phase
    assign setup     = psel_in && !penable_in && ce_in;
    // A latch takes a byte only in write mode with no cycle running and no protection hit
    assign lwr       = wr && hit_arr && lat_q && !pgm_q && !blocked;
    assign arr_rd_ok = !lat_q && !blocked;

    always_comb
    begin
        hit_csr = 1'b0;
        hit_cfg = 1'b0;
        hit_arr = 1'b0;
        if (paddr_in == DEAC_CSR_ADDR)
        begin
            hit_csr = 1'b1;
        end
        else if (paddr_in == DEAC_CFG_ADDR)
        begin
            hit_cfg = 1'b1;
        end
        else if ((paddr_in & DEAC_ARRAY_MASK) == DEAC_ARRAY_BASE)
        begin
            hit_arr = 1'b1;
        end
    end

    // Counter expiry ends the cycle; zero latched bytes still run the full time
    assign done      = (state_q == DEAC_PROG) && (cnt_q == DEAC_CNT_W'(PROG_CYCLES - 1));
    assign lat_fall  = lat_q && !lat_d;
    // Option removal wipes the whole array before access reopens
    assign erase_all = protect_q && !protect_in && ce_in;

    // Reserved bits come from the reset word, which holds them at zero
    always_comb
    begin
        csr_view               = DEAC_CSR_RESET;
        csr_view[DEAC_LAT_BIT] = lat_q;
        csr_view[DEAC_PGM_BIT] = pgm_q;
    end

    // Commit strobe per cell: only latched columns of the captured row are touched
    for (genvar g = 0; g < DEAC_ARRAY_BYTES; g++)
    begin : g_commit
        assign commit[g] = done && lvalid_q[g % DEAC_NUM_LATCH]
                           && (row_q == DEAC_ROW_W'(g / DEAC_NUM_LATCH));
    end

    // Control/status next value
    always_comb
    begin
        lat_d = lat_q;
        pgm_d = pgm_q;
        if (wr && hit_csr && state_q != DEAC_HALT)
        begin
            if (pwdata_in[DEAC_LAT_BIT])
            begin
                lat_d = 1'b1;
            end
            else if (!pgm_q)
            begin
                lat_d = 1'b0;
            end
            // Program bit only starts with latch mode on; a clear mid-cycle is honoured and ends the run with nothing committed
            pgm_d = pwdata_in[DEAC_PGM_BIT] && lat_d;
        end
        if (done || state_q == DEAC_HALT)
        begin
            lat_d = 1'b0;
            pgm_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            lat_q <= DEAC_CSR_RESET[DEAC_LAT_BIT];
            pgm_q <= DEAC_CSR_RESET[DEAC_PGM_BIT];
        end
        else if (ce_in)
        begin
            lat_q <= lat_d;
            pgm_q <= pgm_d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            protect_q <= 1'b0;
        end
        else if (ce_in)
        begin
            protect_q <= protect_in;
        end
    end

    // Cycle timer runs only in the programming state; any other state rearms it from zero
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cnt_q <= '0;
        end
        else if (ce_in)
        begin
            if (state_q == DEAC_PROG)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else
            begin
                cnt_q <= '0;
            end
        end
    end

    // Sequencer; reset drops any cycle in flight and leaves the array as it stands
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_q <= DEAC_IDLE;
        end
        else if (ce_in)
        begin
            case (state_q)
                DEAC_IDLE:
                begin
                    if (halt_req_in)
                    begin
                        state_q <= DEAC_HALT;
                    end
                    else if (pgm_d && !pgm_q)
                    begin
                        state_q <= DEAC_PROG;
                    end
                    else if (wfi_req_in)
                    begin
                        state_q <= DEAC_WAIT;
                    end
                end
                DEAC_PROG:
                begin
                    if (halt_req_in)
                    begin
                        state_q <= DEAC_HALT;
                    end
                    else if (!pgm_d && !done)
                    begin
                        state_q <= DEAC_IDLE;
                    end
                    else if (done)
                    begin
                        state_q <= wfi_req_in ? DEAC_WAIT : DEAC_IDLE;
                    end
                end
                DEAC_WAIT:
                begin
                    if (halt_req_in)
                    begin
                        state_q <= DEAC_HALT;
                    end
                    // A run started from wait must still be timed, or busy would never drop
                    else if (pgm_d && !pgm_q)
                    begin
                        state_q <= DEAC_PROG;
                    end
                    else if (!wfi_req_in)
                    begin
                        state_q <= DEAC_IDLE;
                    end
                end
                DEAC_HALT:
                begin
                    if (!halt_req_in)
                    begin
                        state_q <= DEAC_IDLE;
                    end
                end
                default:
                begin
                    state_q <= DEAC_IDLE;
                end
            endcase
        end
    end

    // Page latches and row capture
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            lvalid_q <= '0;
            row_q    <= '0;
        end
        else if (ce_in)
        begin
            if (done || lat_fall || state_q == DEAC_HALT)
            begin
                lvalid_q <= '0;
            end
            else if (lwr)
            begin
                lvalid_q[col] <= 1'b1;
                row_q         <= row;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (ce_in && !srst_in && lwr)
        begin
            // Unprogrammed latch starts erased so the first write stores plainly
            latch_q[col] <= (lvalid_q[col] ? latch_q[col] : DEAC_ERASED_BYTE)
                            & pwdata_in[7:0];
        end
    end

    // Array cells; no reset so contents survive and stay undefined after an abort
    always_ff @(posedge clk_in)
    begin
        if (ce_in && !srst_in)
        begin
            for (int i = 0; i < DEAC_ARRAY_BYTES; i++)
            begin
                if (erase_all)
                begin
                    mem_q[i] <= DEAC_ERASED_BYTE;
                end
                else if (commit[i])
                begin
                    mem_q[i] <= latch_q[i % DEAC_NUM_LATCH];
                end
            end
        end
    end

    // APB read data; latches have no read path
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            prdata_q <= '0;
        end
        else if (setup)
        begin
            prdata_q <= DEAC_UNDRIVEN_WORD;
            if (hit_csr)
            begin
                prdata_q[7:0] <= csr_view;
            end
            else if (hit_cfg)
            begin
                prdata_q[DEAC_PROT_BIT] <= protect_q;
            end
            else if (hit_arr && arr_rd_ok)
            begin
                prdata_q[7:0] <= mem_q[paddr_in[DEAC_COL_W+DEAC_ROW_W-1:0]];
            end
        end
    end

    // Unmapped addresses answer with an error in the access phase
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            slverr_q <= !(hit_csr || hit_cfg || hit_arr);
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = 1'b1;
    // Error shows only while the access phase is on the bus
    assign pslverr_out = slverr_q && acc;
    // Program bit doubles as the busy flag seen by the core
    assign busy_out    = pgm_q;
    assign wait_out    = (state_q == DEAC_WAIT);
    assign halt_out    = (state_q == DEAC_HALT);
endmodule

// *** test/deac_top_props.sv ***
// Port checker for the data EEPROM access controller.
// Assumes only deac_top ports; the bind hands on the instance's PROG_CYCLES.
`timescale 1ns/1ps
module deac_top_props
    import deac_pkg::*;
#(
    parameter int PROG_CYCLES = DEAC_PROG_CYCLES
)(
    input wire logic        clk_in,        // Clock
    input wire logic        srst_in,       // Reset
    input wire logic        ce_in,         // Enable
    input wire logic        psel_in,       // Bus
    input wire logic        penable_in,    // Bus
    input wire logic        pwrite_in,     // Bus
    input wire logic [11:0] paddr_in,      // Bus
    input wire logic [31:0] pwdata_in,     // Bus
    input wire logic [31:0] prdata_out,    // Bus
    input wire logic        pready_out,    // Bus
    input wire logic        pslverr_out,   // Bus
    input wire logic        wfi_req_in,    // Wait request
    input wire logic        halt_req_in,   // Halt request
    input wire logic        protect_in,    // Protection
    input wire logic        ext_access_in, // External tool
    input wire logic        busy_out,      // Programming
    input wire logic        wait_out,      // Wait state
    input wire logic        halt_out       // Halt state
);
    logic [23:0] busy_cnt_q;
    logic        acc;
    assign acc = psel_in && penable_in && ce_in;
    // Cycles the program bit has been up, so the self-timed length is bounded
    always_ff @(posedge clk_in)
    begin
        if (srst_in || !busy_out)
            busy_cnt_q <= 24'h0;
        else
            busy_cnt_q <= busy_cnt_q + 24'h1;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_idle_wfi;
        wfi_req_in && !busy_out && !halt_req_in;
    endsequence
    sequence s_array_read;
        acc && !pwrite_in && ((paddr_in & DEAC_ARRAY_MASK) == DEAC_ARRAY_BASE);
    endsequence
    a_prog_cause: assert property ($rose(busy_out) |->
        $past(acc && pwrite_in && paddr_in == DEAC_CSR_ADDR && pwdata_in[DEAC_PGM_BIT])) else $error("busy without start");
    a_cycle_bounded: assert property (busy_out |-> busy_cnt_q <= PROG_CYCLES)
        else $error("programming too long");
    a_wait_idle: assert property (s_idle_wfi |-> ##[1:2] wait_out)
        else $error("wait not entered");
    a_wait_after_prog: assert property (wait_out |-> !busy_out)
        else $error("wait while programming");
    a_halt_abandons: assert property (halt_req_in |-> ##[1:2] (halt_out && !busy_out))
        else $error("halt not immediate");
    a_protect_blank: assert property (s_array_read ##0 (protect_in && ext_access_in) |-> prdata_out == 32'h0)
        else $error("protected data visible");
    a_csr_reserved: assert property (acc && !pwrite_in && paddr_in == DEAC_CSR_ADDR |->
        prdata_out[31:2] == 30'h0) else $error("reserved bits set");
    a_reset_clears: assert property (@(posedge clk_in) disable iff (1'b0) srst_in |=>
        !busy_out && !wait_out && !halt_out) else $error("state after reset");
endmodule

bind deac_top deac_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.*);

// *** test/deac_cpu_model.sv ***
// CPU core model: APB master issuing one transfer per task call.
// Assumes the bench calls xfer hierarchically, never two at once.
`timescale 1ns/1ps
module deac_cpu_model
(
    input  wire logic        clk_in,      // Clock
    output logic             psel_out,    // Select
    output logic             penable_out, // Enable
    output logic             pwrite_out,  // Direction
    output logic      [11:0] paddr_out,   // Address
    output logic      [31:0] pwdata_out,  // Write data
    input  wire logic [31:0] prdata_in,   // Read data
    input  wire logic        pready_in,   // Ready
    input  wire logic        pslverr_in   // Error
);
    initial
    begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0;
    end
    // Callers keep one row per run, never drop the program bit mid-cycle
    // and never fetch code from the array
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do
            @(posedge clk_in);
        while (pready_in !== 1'b1);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // A released bus must not keep showing the last value
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask
endmodule

// *** test/deac_top_test.sv ***
// Self-checking bench for the data EEPROM access controller.
// Assumes deac_cpu_model as bus master and a shortened programming time.
`timescale 1ns/1ps
module deac_top_test
    import deac_pkg::*;
;
    localparam int PC = 12;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        wfi_req_in = 1'b0;
    logic        halt_req_in = 1'b0;
    logic        protect_in = 1'b0;
    logic        ext_access_in = 1'b0;
    logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out, busy_out, wait_out, halt_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic        e;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #25 clk_in = ~clk_in;
    deac_top #(.PROG_CYCLES(PC)) dut (.*);
    deac_cpu_model cpu (.clk_in(clk_in), .psel_out(psel_in), .penable_out(penable_in), .pwrite_out(pwrite_in),
        .paddr_out(paddr_in), .pwdata_out(pwdata_in), .prdata_in(prdata_out), .pready_in(pready_out),
        .pslverr_in(pslverr_out));

    function automatic logic [7:0] pat(input int k);
        return 8'(k * 29 + 17);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic err);
        cpu.xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk(e, err);
    endtask
    task automatic run_prog;
        wr(DEAC_CSR_ADDR, 8'h03);
        @(negedge clk_in);
        chk(busy_out, 1'b1);
        while (busy_out === 1'b1)
            @(negedge clk_in);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        chk({busy_out, wait_out, halt_out}, 3'b000);
        wr(DEAC_CSR_ADDR, 8'hfc);
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        rdc(12'h100, 32'h0, 1'b1);
        $display("test reset_map done");
        wr(DEAC_CSR_ADDR, 8'h02);
        for (int k = 0; k < 32; k++)
            wr(12'h820 + 12'(k), pat(k));
        wr(12'h824, 8'h3c);
        rdc(DEAC_CSR_ADDR, 32'h2, 1'b0);
        rdc(12'h824, 32'h0, 1'b0);
        run_prog();
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        for (int k = 0; k < 32; k++)
            rdc(12'h820 + 12'(k), {24'h0, (k == 4) ? (pat(4) & 8'h3c) : pat(k)}, 1'b0);
        wr(12'h825, 8'h00);
        rdc(12'h825, {24'h0, pat(5)}, 1'b0);
        $display("test row_program done");
        wr(DEAC_CSR_ADDR, 8'h02);
        wr(12'h826, 8'h00);
        wr(DEAC_CSR_ADDR, 8'h00);
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        wr(DEAC_CSR_ADDR, 8'h02);
        wr(12'h826, 8'h0f);
        run_prog();
        rdc(12'h826, 32'h0f, 1'b0);
        $display("test latch_clear done");
        wr(DEAC_CSR_ADDR, 8'h03); // Empty run, both bits in one write
        wr(DEAC_CSR_ADDR, 8'h01);
        wfi_req_in <= 1'b1;
        rdc(DEAC_CSR_ADDR, 32'h3, 1'b0);
        @(negedge clk_in);
        chk(wait_out, 1'b0);
        while (busy_out === 1'b1)
            @(negedge clk_in);
        repeat (2) @(negedge clk_in);
        chk(wait_out, 1'b1);
        @(posedge clk_in);
        wfi_req_in <= 1'b0;
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        $display("test wait_mode done");
        wr(DEAC_CSR_ADDR, 8'h02);
        wr(12'h830, 8'h00);
        wr(DEAC_CSR_ADDR, 8'h03);
        halt_req_in <= 1'b1;
        repeat (3) @(negedge clk_in);
        chk({busy_out, halt_out}, 2'b01);
        @(posedge clk_in);
        halt_req_in <= 1'b0;
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        wr(DEAC_CSR_ADDR, 8'h02);
        wr(12'h831, 8'h00);
        wr(DEAC_CSR_ADDR, 8'h03);
        srst_in <= 1'b1;
        @(posedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        chk(busy_out, 1'b0);
        rdc(DEAC_CSR_ADDR, 32'h0, 1'b0);
        $display("test halt_reset done");
        protect_in <= 1'b1;
        ext_access_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rdc(DEAC_CFG_ADDR, 32'h1, 1'b0);
        rdc(12'h820, 32'h0, 1'b0);
        protect_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rdc(12'h820, 32'hff, 1'b0);
        $display("test protection done");
        report_and_stop();
    end
endmodule
